// *** shared/swlm_regs.svh ***
// Constants for the SRAM write lane mask block.
// Assumes inclusion by bare name from shared/.
`ifndef SWLM_REGS_SVH
`define SWLM_REGS_SVH

`define SWLM_DATA_W      36
`define SWLM_SEL_W       4
`define SWLM_NIBBLE_W    4
`define SWLM_LANE_W      9
`define SWLM_W8_BITS     8
`define SWLM_W9_BITS     9
`define SWLM_W18_BITS    18
`define SWLM_ADDR_W      6
`define SWLM_BURST_CYC   2
`define SWLM_FIFO_DEPTH  16
`define SWLM_CLK_MHZ     50
`define SWLM_CNT_W       2
`define SWLM_CNT_ZERO    2'h0
`define SWLM_CNT_ONE     2'h1
`define SWLM_PAIR_STEP   2

`endif

// *** shared/swlm_pkg.sv ***
// Types for the SRAM write lane mask block.
// Assumes swlm_regs.svh is on the include path.
`include "swlm_regs.svh"

package swlm_pkg;

   // Organisation of the data bus
   typedef enum logic [1:0] {
      SWLM_ORG_8  = 2'b00,
      SWLM_ORG_9  = 2'b01,
      SWLM_ORG_18 = 2'b10,
      SWLM_ORG_36 = 2'b11
   } swlm_org_type;

   // One clock cycle of a burst: true-edge and complement-edge beats
   typedef struct packed {
      logic [`SWLM_ADDR_W-1:0] addr;
      logic [`SWLM_DATA_W-1:0] data_rise;
      logic [`SWLM_DATA_W-1:0] mask_rise;
      logic [`SWLM_DATA_W-1:0] data_fall;
      logic [`SWLM_DATA_W-1:0] mask_fall;
   } swlm_pair_type;

endpackage

// *** hdl/swlm_top.sv ***
// Write lane masking path of a burst synchronous SRAM, with beat FIFO and array.
// Assumes all inputs synchronous to i_clk; both clock edges of a beat pair
// arrive together as one rise and one fall beat per i_clk cycle.
// ORG is fixed at build time; bits outside the organisation are never written.
// The array has no reset, so a location reads unknown until first written.
//
// Notes on behaviour
// (RL1) Lane selects are sampled with every beat, true and complement edge alike, and affect that beat only.
// (RL2) In 8-bit mode the low nibble select writes bits 3:0 and the high one bits 7:4, else kept.
// (RL3) In 18-bit mode select 0 writes bits 8:0 and select 1 bits 17:9, a high select keeps its lane.
// (RL4) In 9-bit mode one select gates bits 8:0, high means nothing is written.
// (RL5) In 36-bit mode selects 0 to 3 gate bits 8:0, 17:9, 26:18 and 35:27, each on its own.
// (RL6) In 36-bit mode all selects low writes the full 36-bit beat.
// (RL7) All selects high writes nothing and leaves the location unchanged.
// (RL8) The controller may change the select pattern from beat to beat and each is honoured.
// (RL9) Masking and writes occur only for beats of a burst started through the write port select.
// (RL10) A burst latches its address at a start and its beats follow in the next cycles to successive addresses.
// (RL11) A write start in the cycle right after a write start is ignored.
// (RL12) Each beat's mask is registered with its data and turned into per-bit array write enables.
`timescale 1ns/1ps
`include "swlm_regs.svh"

// ************************************************************
// Synchronous FIFO
// ************************************************************
module swlm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `SWLM_FIFO_DEPTH
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_srst,
   input  wire logic                     i_ce,
   input  wire logic                     i_in_valid,
   output logic                          o_in_ready,
   input  wire logic [WIDTH-1:0]         i_in_data,
   output logic                          o_out_valid,
   input  wire logic                     i_out_ready,
   output logic      [WIDTH-1:0]         o_out_data,
   output logic      [$clog2(DEPTH):0]   o_level
);

   localparam int PW = $clog2(DEPTH);

   // Pointer step with wrap, so depths need not be a power of two
   function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] ptr);
      return (ptr == PW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
   endfunction

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;

   // ************************************************************
   // Flow control
   // ************************************************************
   wire push = i_ce && i_in_valid && o_in_ready;
   wire pop  = i_ce && o_out_valid && i_out_ready;

   // Count is one bit wider than the pointers, so full and empty differ
   assign o_in_ready  = (count != (PW + 1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign o_out_data  = store[rd_ptr];
   assign o_level     = count;

   // ************************************************************
   // Storage
   // ************************************************************
   // Not reset: only counted entries are ever read
   always_ff @(posedge i_clk) begin
      if (push) begin
         store[wr_ptr] <= i_in_data;
      end
   end

   // ************************************************************
   // Pointers and level
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wrap_inc(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= wrap_inc(rd_ptr);
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule

// ************************************************************
// Top: burst sequencing, lane decode, array
// ************************************************************
module swlm_top #(
   parameter swlm_pkg::swlm_org_type ORG = swlm_pkg::SWLM_ORG_36,
   parameter int AW         = `SWLM_ADDR_W,
   parameter int FIFO_DEPTH = `SWLM_FIFO_DEPTH
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_srst,
   input  wire logic                      i_ce,
   input  wire logic                      i_write_port_select_n,
   input  wire logic [AW-1:0]             i_wr_addr,
   input  wire logic [`SWLM_DATA_W-1:0]   i_data_rise,
   input  wire logic [`SWLM_SEL_W-1:0]    i_lane_select_rise_n,
   input  wire logic [`SWLM_DATA_W-1:0]   i_data_fall,
   input  wire logic [`SWLM_SEL_W-1:0]    i_lane_select_fall_n,
   input  wire logic                      i_array_hold,
   input  wire logic [AW-1:0]             i_rd_addr,
   output logic      [`SWLM_DATA_W-1:0]   o_rd_data,
   output logic                           o_ready,
   output logic                           o_drop
);

   localparam int DW = `SWLM_DATA_W;

   // ************************************************************
   // Lane decode
   // ************************************************************
   // Bit i of the result is a write enable; selects are active low.
   function automatic logic [DW-1:0] lane_mask(
      input swlm_pkg::swlm_org_type org,
      input logic [`SWLM_SEL_W-1:0] sel_n
   );
      logic [DW-1:0] m;
      m = '0;
      for (int i = 0; i < DW; i++) begin
         unique case (org)
            swlm_pkg::SWLM_ORG_8: begin
               // [RL2]
               m[i] = (i < `SWLM_W8_BITS) && !sel_n[i / `SWLM_NIBBLE_W];
            end
            swlm_pkg::SWLM_ORG_9: begin
               // [RL4]
               m[i] = (i < `SWLM_W9_BITS) && !sel_n[0];
            end
            swlm_pkg::SWLM_ORG_18: begin
               // [RL3]
               m[i] = (i < `SWLM_W18_BITS) && !sel_n[i / `SWLM_LANE_W];
            end
            swlm_pkg::SWLM_ORG_36: begin
               // All low gives all ones, all high gives zero [RL5] [RL6] [RL7]
               m[i] = !sel_n[i / `SWLM_LANE_W];
            end
         endcase
      end
      return m;
   endfunction

   // Merge a beat into a stored word under its bit enables
   function automatic logic [DW-1:0] merge(
      input logic [DW-1:0] old_word,
      input logic [DW-1:0] new_word,
      input logic [DW-1:0] en
   );
      return (old_word & ~en) | (new_word & en);
   endfunction

   // ************************************************************
   // Burst sequencing
   // ************************************************************
   logic [`SWLM_CNT_W-1:0] beat_cnt;
   logic [AW-1:0]          base_addr;
   logic                   prev_start;

   logic [`SWLM_CNT_W-1:0] next_beat_cnt;
   logic [AW-1:0]          next_base_addr;

   // A start in the last data cycle overlaps; that cycle's pair is still pushed
   // Back-to-back starts are refused, not queued [RL11]
   wire start     = !i_write_port_select_n && !prev_start;
   wire data_cyc  = (beat_cnt != `SWLM_CNT_ZERO);

   // Successive burst addresses, two beats per cycle [RL10]
   wire [`SWLM_CNT_W-1:0] pair_idx =
      `SWLM_CNT_W'(`SWLM_BURST_CYC) - beat_cnt;
   wire [AW-1:0] pair_addr =
      base_addr + AW'(pair_idx) * AW'(`SWLM_PAIR_STEP);

   assign next_base_addr = start ? i_wr_addr : base_addr; // [RL10]
   assign next_beat_cnt  = start    ? `SWLM_CNT_W'(`SWLM_BURST_CYC) :
                           data_cyc ? beat_cnt - `SWLM_CNT_ONE :
                                      `SWLM_CNT_ZERO;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         beat_cnt   <= `SWLM_CNT_ZERO;
         base_addr  <= '0;
         prev_start <= 1'b0;
      end else if (i_ce) begin
         beat_cnt   <= next_beat_cnt;
         base_addr  <= next_base_addr;
         prev_start <= start;
      end
   end

   // ************************************************************
   // Beat capture into the FIFO
   // ************************************************************
   swlm_pkg::swlm_pair_type in_pair;
   swlm_pkg::swlm_pair_type out_pair;

   logic                       fifo_in_ready;
   logic                       fifo_out_valid;
   logic [$clog2(FIFO_DEPTH):0] fifo_level;

   // Whole pairs are queued so that a held array never stalls the controller
   // Masks only exist for beats inside a burst [RL9]
   wire push_req = data_cyc;

   // Each edge carries its own select pattern [RL1] [RL8] [RL12]
   assign in_pair.addr      = pair_addr;
   assign in_pair.data_rise = i_data_rise;
   assign in_pair.mask_rise = lane_mask(ORG, i_lane_select_rise_n);
   assign in_pair.data_fall = i_data_fall;
   assign in_pair.mask_fall = lane_mask(ORG, i_lane_select_fall_n);

   wire drain = !i_array_hold;

   swlm_fifo #(
      .WIDTH ($bits(swlm_pkg::swlm_pair_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_srst      (i_srst),
      .i_ce        (i_ce),
      .i_in_valid  (push_req),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (in_pair),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (drain),
      .o_out_data  (out_pair),
      .o_level     (fifo_level)
   );

   // ************************************************************
   // Status outputs
   // ************************************************************
   // Room for a whole burst must remain, as the controller cannot pause mid-burst
   wire [$clog2(FIFO_DEPTH):0] room_limit =
      ($clog2(FIFO_DEPTH) + 1)'(FIFO_DEPTH - `SWLM_BURST_CYC);
   wire next_ready = (fifo_level <= room_limit);
   // A pair lost on a full FIFO is gone; o_drop is its only trace
   wire next_drop  = push_req && !fifo_in_ready;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_ready <= 1'b0;
         o_drop  <= 1'b0;
      end else if (i_ce) begin
         o_ready <= next_ready;
         o_drop  <= next_drop;
      end
   end

   // ************************************************************
   // Array
   // ************************************************************
   logic [DW-1:0] mem [0:(2**AW)-1];

   // Two write ports: rise and fall beats of a pair land at one edge
   wire do_write           = i_ce && fifo_out_valid && drain;
   wire [AW-1:0] addr_fall = out_pair.addr + AW'(1);

   // Disabled lanes keep their stored bits [RL12] [RL7]
   wire [DW-1:0] word_rise =
      merge(mem[out_pair.addr], out_pair.data_rise, out_pair.mask_rise);
   wire [DW-1:0] word_fall =
      merge(mem[addr_fall], out_pair.data_fall, out_pair.mask_fall);

   always_ff @(posedge i_clk) begin
      if (do_write) begin
         mem[out_pair.addr] <= word_rise;
         mem[addr_fall]     <= word_fall;
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   // A read at the edge of a write returns the contents before it
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rd_data <= '0;
      end else if (i_ce) begin
         o_rd_data <= mem[i_rd_addr];
      end
   end

endmodule

// *** test/swlm_ctrl_model.sv ***
// Controller model: one write burst per i_go, released data and address lines toggle, selects held low.
// Assumes i_go pulses come at least two cycles apart.
`timescale 1ns/1ps
// ******************
// Burst driver
// ******************
module swlm_ctrl_model #(parameter int AW = 6) (
   input  wire logic                i_clk,
   input  wire logic                i_go,
   input  wire logic                i_dbl,
   input  wire logic [AW-1:0]       i_addr,
   input  wire logic [143:0]        i_data,
   input  wire logic [15:0]         i_sel_n,
   output logic                     o_wps_n = 1'h1,
   output logic      [AW-1:0]       o_addr = '0,
   output logic      [71:0]         o_data = '0,
   output logic      [7:0]          o_sel_n = '0
);
   logic [1:0]   phase = 2'h0;
   logic [143:0] data = '0;
   logic [15:0]  sel = '0;
   logic         dbl = 1'h0;
   always @(posedge i_clk) begin
      phase   <= i_go ? 2'h1 : {phase == 2'h1, 1'h0};
      o_wps_n <= !(i_go || (phase == 2'h1 && dbl));
      o_addr  <= i_go ? i_addr : ~o_addr;
      if (i_go) begin
         data <= i_data;
         sel  <= i_sel_n;
         dbl  <= i_dbl;
      end
      // Own selects per beat
      if (phase == 2'h1) begin
         o_data  <= data[71:0];
         o_sel_n <= sel[7:0];
      end else if (phase == 2'h2) begin
         o_data  <= data[143:72];
         o_sel_n <= sel[15:8];
      end else begin
         // Selects low outside bursts to tempt stray writes
         o_data  <= ~o_data;
         o_sel_n <= 8'h00;
      end
   end
endmodule

// *** test/swlm_top_asserts.sv ***
// Port checker for the write lane mask top.
// Assumes i_ce is held high.
`timescale 1ns/1ps
`include "swlm_regs.svh"
// ******************
// Port checks
// ******************
module swlm_top_asserts #(parameter int AW = 6) (
   input wire logic                    i_clk,
   input wire logic                    i_srst,
   input wire logic                    i_write_port_select_n,
   input wire logic                    i_array_hold,
   input wire logic [AW-1:0]           i_rd_addr,
   input wire logic [`SWLM_DATA_W-1:0] o_rd_data,
   input wire logic                    o_ready,
   input wire logic                    o_drop
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   a_reset_values: assert property ($fell(i_srst) |-> !o_ready && !o_drop && o_rd_data == '0)
      else $error("outputs not cleared by reset");
   a_ready_return: assert property ($fell(i_srst) |-> ##[1:3] o_ready)
      else $error("ready missing after reset");
   a_drop_start: assert property (o_drop |-> !$past(i_write_port_select_n, 2)
      || !$past(i_write_port_select_n, 3))
      else $error("drop without a burst");
   a_drop_full: assert property (o_drop |-> !o_ready)
      else $error("drop while ready");
   a_drop_after_full: assert property (o_drop |-> !$past(o_ready))
      else $error("drop after ready");
   a_ready_fall: assert property ($fell(o_ready) |-> !$past(i_write_port_select_n, 1)
      || !$past(i_write_port_select_n, 2) || !$past(i_write_port_select_n, 3)
      || !$past(i_write_port_select_n, 4) || !$past(i_write_port_select_n, 5))
      else $error("ready fell without beats");
   a_ready_rise: assert property ($rose(o_ready) |-> $past(i_srst, 2) || $past(i_srst, 3)
      || !$past(i_array_hold, 1) || !$past(i_array_hold, 2))
      else $error("ready rose without drain");
   a_hold_keeps: assert property ($past(i_array_hold) && $past(i_array_hold, 2)
      && $past(i_rd_addr) == $past(i_rd_addr, 2) && !$past(i_srst) && !$past(i_srst, 2)
      |-> $stable(o_rd_data))
      else $error("array changed while held");
endmodule

// *** test/test_swlm_top.sv ***
// Self-checking bench for the write lane mask top, all four organisations on one link.
// Assumes the controller model and checker compile first.
`timescale 1ns/1ps
`include "swlm_regs.svh"
// ******************
// Bench
// ******************
module test_swlm_top;
   localparam int AW = 6;
   logic          i_clk = 1'h0;
   logic          i_srst = 1'h1;
   logic          go = 1'h0;
   logic          dbl = 1'h0;
   logic          hold = 1'h0;
   logic [AW-1:0] addr = '0;
   logic [AW-1:0] rd_addr = '0;
   logic [143:0]  bdata = '0;
   logic [15:0]   bsel = '0;
   logic          wps_n;
   logic          ready;
   logic          drop;
   logic [AW-1:0] wr_addr;
   logic [71:0]   pdata;
   logic [7:0]    psel;
   logic [35:0]   rd_data;
   logic [35:0]   rd_org [3];
   logic [35:0]   shadow [4][64];
   int            error_cnt = 0;
   int            n_compared = 0;
   int            drops = 0;
   int            seed = 67;
   always #10 i_clk = ~i_clk;
   always @(posedge i_clk) if (drop === 1'h1) drops <= drops + 1;
   swlm_ctrl_model #(.AW(AW)) i_ctrl (.i_clk(i_clk), .i_go(go), .i_dbl(dbl), .i_addr(addr), .i_data(bdata),
      .i_sel_n(bsel), .o_wps_n(wps_n), .o_addr(wr_addr), .o_data(pdata), .o_sel_n(psel));
   swlm_top #(.ORG(swlm_pkg::SWLM_ORG_36), .AW(AW)) i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'h1),
      .i_write_port_select_n(wps_n), .i_wr_addr(wr_addr), .i_data_rise(pdata[35:0]),
      .i_lane_select_rise_n(psel[3:0]), .i_data_fall(pdata[71:36]), .i_lane_select_fall_n(psel[7:4]),
      .i_array_hold(hold), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_ready(ready), .o_drop(drop));
   // Narrower organisations share the link; only their readback differs
   for (genvar g = 0; g < 3; g++) begin : g_org
      swlm_top #(.ORG(swlm_pkg::swlm_org_type'(g)), .AW(AW)) i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'h1),
         .i_write_port_select_n(wps_n), .i_wr_addr(wr_addr), .i_data_rise(pdata[35:0]),
         .i_lane_select_rise_n(psel[3:0]), .i_data_fall(pdata[71:36]), .i_lane_select_fall_n(psel[7:4]),
         .i_array_hold(hold), .i_rd_addr(rd_addr), .o_rd_data(rd_org[g]), .o_ready(), .o_drop());
   end
   // Organisation 0: two 4-bit lanes, 1: one 9-bit lane, 2: two 9-bit lanes, 3: four 9-bit lanes
   function automatic logic [35:0] merge(input int org, input logic [35:0] o, input logic [35:0] n,
                                         input logic [3:0] s);
      int lw;
      int nl;
      lw = (org == 0) ? 4 : 9;
      nl = (org == 1) ? 1 : ((org == 3) ? 4 : 2);
      for (int l = 0; l < nl; l++) if (!s[l]) for (int b = 0; b < lw; b++) o[lw*l + b] = n[lw*l + b];
      return o;
   endfunction
   function automatic logic [143:0] rnd();
      return {$random(seed), $random(seed), $random(seed), $random(seed), 16'($random(seed))};
   endfunction
   task automatic cmp(input string nm, input logic [35:0] exp, input logic [35:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic burst(input logic [AW-1:0] a, input logic [143:0] d, input logic [15:0] s, input logic rf,
                        input logic upd);
      go <= 1'h1;
      dbl <= rf;
      addr <= a;
      bdata <= d;
      bsel <= s;
      @(posedge i_clk);
      go <= 1'h0;
      @(posedge i_clk);
      if (upd) for (int g = 0; g < 4; g++) for (int b = 0; b < 4; b++)
         shadow[g][(a + b) % 64] = merge(g, shadow[g][(a + b) % 64], d[36*b +: 36], s[4*b +: 4]);
   endtask
   task automatic check_all();
      hold <= 1'h0;
      repeat (24) @(posedge i_clk);
      for (int i = 0; i < 64; i++) begin
         rd_addr <= AW'(i);
         @(posedge i_clk);
         @(negedge i_clk);
         cmp("rd_data", shadow[3][i], rd_data);
         cmp("rd_data_8", shadow[0][i], rd_org[0]);
         cmp("rd_data_9", shadow[1][i], rd_org[1]);
         cmp("rd_data_18", shadow[2][i], rd_org[2]);
         @(posedge i_clk);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge i_clk);
      i_srst <= 1'h0;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      cmp("ready", 36'h1, {35'h0, ready});
      @(posedge i_clk);
      for (int a = 0; a < 64; a += 4) burst(AW'(a), rnd(), 16'h0, 1'h0, 1'h1);
      // Corner patterns first: all kept, then one lane per beat
      for (int k = 0; k < 48; k++) begin
         burst(AW'($random(seed)), rnd(), k < 2 ? (k == 0 ? 16'hFFFF : 16'hEDB7) : 16'($random(seed)),
               1'(k % 4 == 3), 1'h1);
         if (k % 2 == 1) @(posedge i_clk);
      end
      check_all();
      hold <= 1'h1;
      for (int k = 0; k < 9; k++) burst(AW'(k * 4), rnd(), 16'h0, 1'h0, 1'(k < 8));
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      cmp("drops", 36'h2, 36'(drops));
      cmp("ready", 36'h0, {35'h0, ready});
      @(posedge i_clk);
      check_all();
      test_done();
   end
endmodule
bind swlm_top swlm_top_asserts #(.AW(AW)) i_chk (.i_clk(i_clk), .i_srst(i_srst),
   .i_write_port_select_n(i_write_port_select_n), .i_array_hold(i_array_hold), .i_rd_addr(i_rd_addr),
   .o_rd_data(o_rd_data), .o_ready(o_ready), .o_drop(o_drop));
